// [core/dfs_defs.vh]
// Offsets, field positions and reset values of the status and test bank
`ifndef DFS_DEFS_VH
`define DFS_DEFS_VH
// Register offsets (byte addresses)
`define DFS_AUX_STATUS 8'h15
`define DFS_MAILBOX0 8'h16
`define DFS_MAILBOX1 8'h17
`define DFS_EMPTY_LANES 8'h18
`define DFS_FULL_LANES 8'h19
`define DFS_CFG_SHADOW 8'h1a
`define DFS_FLUSH_CLEAR 8'h1b
`define DFS_RET_PTR0 8'h1c
`define DFS_RET_PTR1 8'h1d
`define DFS_RET_PTR2 8'h1e
`define DFS_RET_PTR3 8'h1f
`define DFS_RESERVED 8'h20
`define DFS_LANE_TEST 8'h21
`define DFS_CNT_STEP 8'h22
`define DFS_FIFO_PORT 8'h23
`define DFS_TBL_BASE0 8'h10
`define DFS_TBL_BASE3 8'h13
// Field positions
`define DFS_FLUSHING_BIT 2
`define DFS_RUNNING_BIT 1
`define DFS_MASK_BIT 0
`define DFS_SIG_PROC_BIT 6
`define DFS_IO_EN_BIT 5
`define DFS_MEM_EN_BIT 4
`define DFS_CIE_BIT 3
`define DFS_FLUSH_BIT 3
`define DFS_CLEAR_BIT 2
`define DFS_WINV_BIT 0
`define DFS_STEER_BIT 6
`define DFS_SHADOW_BIT 4
`define DFS_PARITY_EN_BIT 3
`define DFS_ADDR_STEP_BIT 7
`define DFS_CNT_STEP_BIT 6
`define DFS_BURST_MSB_BIT 2
// Reset values
`define DFS_EMPTY_RESET 8'hff
`define DFS_ZERO_BYTE 8'h00
`endif

// [core/dfs_regs.v]
// Status, mailbox and FIFO test register bank of one channel function
//
// Behaviour
// - Flushing flag reads 1 while the FIFO flushes; writes ignored.
// - Running flag reads 1 while the sequencer executes; writes ignored.
// - Mask bit disables the function interrupt line; always writable.
// - A line already asserted stays until serviced, then blocks.
// - Both mailboxes readable and writable by host and sequencer.
// - Empty-lane byte, one bit per lane, resets to all ones.
// - Full-lane byte, one bit per lane, all set means full.
// - Shadow control mirrors signal-process flag; reading it clears it.
// - Two read-only bits report I/O and memory space enable.
// - Config-info enable makes pad and selector reads return config.
// - Flush control moves FIFO data to memory; software clears it.
// - Clear control resets FIFO pointers then clears itself.
// - Write-and-invalidate only when this and config bit are set.
// - Return pointer captured on call, loaded on return, kept on moves.
// - Shadow test mode redirects return and table base to shadows.
// - Master parity enable gates master parity error interrupts.
// - Lane steer selects test port lane, else next address bits 2:0.
// - Address step increments next address, then self-clears.
// - Counter step decrements 24-bit byte counter, then self-clears.
// - Test port write loads lane top, read unloads lane bottom.
// - Bit 2 of counter-step control is burst length MSB.
`timescale 1ns/1ps
`include "dfs_defs.vh"

module dfs_regs #(
  parameter LANES = 8,
  parameter DEPTH = 4,
  parameter PW = 2
) (
  input wire CORE_CLK,
  input wire RST_B,
  input wire [7:0] ADDR,
  input wire [31:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [31:0] RDATA,
  // Sequencer side
  input wire SEQ_RUNNING,
  input wire SEQ_MBOX_WR,
  input wire SEQ_MBOX_SEL,
  input wire [7:0] SEQ_MBOX_DATA,
  output reg [7:0] MAILBOX_ZERO,
  output reg [7:0] MAILBOX_ONE,
  input wire SEQ_CALL,
  input wire SEQ_RETURN,
  input wire [31:0] CALL_RETURN_ADDR,
  input wire MEM_MOVE,
  output reg FETCH_LOAD,
  output reg [31:0] FETCH_POINTER,
  input wire [31:0] TABLE_BASE_IN,
  output reg [31:0] SHADOW_TABLE_BASE,
  // Signal process flag of the main status register
  input wire SIGNAL_PROCESS_FLAG,
  output reg SIGNAL_PROCESS_CLR,
  // Configuration values (from config space, same clock)
  input wire IO_SPACE_ENABLED,
  input wire MEMORY_SPACE_ENABLED,
  input wire CMD_WRITE_INVALIDATE,
  input wire [63:0] REG_BASE,
  input wire [63:0] RAM_BASE,
  input wire [7:0] REVISION_ID_VALUE,
  input wire [15:0] DEVICE_ID_VALUE,
  input wire [2:0] PAD_SEL,
  input wire [31:0] PAD_NORMAL,
  output reg [31:0] PAD_READ,
  // DMA engine
  input wire FLUSH_DONE,
  output reg FLUSHING,
  output reg FLUSH_DIRECTION_SIGNAL,
  output reg WRITE_INVALIDATE_OK,
  output reg MASTER_PARITY_ENABLE,
  input wire MASTER_PARITY_ERR,
  output reg PARITY_IRQ,
  output reg [2:0] BURST_LENGTH_MSB,
  input wire [31:0] ADDR_LOAD,
  input wire ADDR_LOAD_EN,
  input wire [23:0] COUNT_LOAD,
  input wire COUNT_LOAD_EN,
  output reg [31:0] NEXT_TRANSFER_ADDRESS,
  output reg [23:0] TRANSFER_BYTE_COUNTER,
  input wire [1:0] DMODE_BL,
  // Interrupt line of this function
  input wire IRQ_REQUEST,
  input wire IRQ_SERVICED,
  output reg IRQ_LINE_B
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  reg [7:0] fifo_mem [0:LANES*DEPTH-1];
  reg [PW:0] top [0:LANES-1];
  reg [PW:0] bot [0:LANES-1];
  reg irq_mask;
  reg cfg_info_en;
  reg flush_ctl;
  reg winv_en;
  reg steer_en;
  reg shadow_mode;
  reg [2:0] lane_sel;
  reg burst_msb;
  reg [31:0] return_pointer;
  reg [31:0] shadow_return_pointer;
  reg [7:0] last_bottom [0:LANES-1];
  reg [7:0] empty_flags;
  reg [7:0] full_flags;
  reg [31:0] next_rdata;
  reg [2:0] auto_lane;
  reg [2:0] cur_lane;
  reg irq_blocked;
  integer i;
  integer j;

  wire wr_rp = WR && ADDR >= `DFS_RET_PTR0 && ADDR <= `DFS_RET_PTR3;
  wire wr_tb = WR && ADDR >= `DFS_TBL_BASE0 && ADDR <= `DFS_TBL_BASE3;
  wire port_wr = WR && ADDR == `DFS_FIFO_PORT;
  wire port_rd = RD && ADDR == `DFS_FIFO_PORT;

  // Byte-granular step size from address alignment and count
  function [3:0] step_size;
    input [31:0] a;
    input [23:0] c;
    reg [3:0] room;
    begin
      room = 4'h8 - {1'b0, a[2:0]};
      if ({20'h0, room} > c)
        step_size = c[3:0];
      else
        step_size = room;
    end
  endfunction

  // Lane currently reached by the test port
  always @* begin
    auto_lane = NEXT_TRANSFER_ADDRESS[2:0];
    cur_lane = steer_en ? lane_sel : auto_lane;
  end

  // ---------------------------------------------------------------
  // Lane flags
  // ---------------------------------------------------------------
  always @* begin
    for (i = 0; i < LANES; i = i + 1) begin
      empty_flags[i] = top[i] == bot[i];
      full_flags[i] = top[i][PW-1:0] == bot[i][PW-1:0] &&
        top[i][PW] != bot[i][PW];
    end
  end

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  always @* begin
    next_rdata = 32'h0;
    case (ADDR)
      `DFS_AUX_STATUS: begin
        next_rdata[`DFS_FLUSHING_BIT] = FLUSHING;
        next_rdata[`DFS_RUNNING_BIT] = SEQ_RUNNING;
        next_rdata[`DFS_MASK_BIT] = irq_mask;
      end
      `DFS_MAILBOX0: next_rdata[7:0] = MAILBOX_ZERO;
      `DFS_MAILBOX1: next_rdata[7:0] = MAILBOX_ONE;
      `DFS_EMPTY_LANES: next_rdata[7:0] = empty_flags;
      `DFS_FULL_LANES: next_rdata[7:0] = full_flags;
      `DFS_CFG_SHADOW: begin
        next_rdata[`DFS_SIG_PROC_BIT] = SIGNAL_PROCESS_FLAG;
        next_rdata[`DFS_IO_EN_BIT] = IO_SPACE_ENABLED;
        next_rdata[`DFS_MEM_EN_BIT] = MEMORY_SPACE_ENABLED;
        next_rdata[`DFS_CIE_BIT] = cfg_info_en;
      end
      `DFS_FLUSH_CLEAR: begin
        next_rdata[`DFS_FLUSH_BIT] = flush_ctl;
        next_rdata[`DFS_WINV_BIT] = winv_en;
      end
      `DFS_RET_PTR0:
        next_rdata = shadow_mode ? shadow_return_pointer : return_pointer;
      `DFS_TBL_BASE0:
        next_rdata = shadow_mode ? SHADOW_TABLE_BASE : TABLE_BASE_IN;
      `DFS_LANE_TEST: begin
        next_rdata[`DFS_STEER_BIT] = steer_en;
        next_rdata[`DFS_SHADOW_BIT] = shadow_mode;
        next_rdata[`DFS_PARITY_EN_BIT] = MASTER_PARITY_ENABLE;
        next_rdata[2:0] = lane_sel;
      end
      `DFS_CNT_STEP: next_rdata[`DFS_BURST_MSB_BIT] = burst_msb;
      `DFS_FIFO_PORT:
        next_rdata[7:0] = fifo_mem[{cur_lane, bot[cur_lane][PW-1:0]}];
      default: next_rdata = 32'h0;
    endcase
  end

  // Config-info substitution for the pad and selector registers
  always @* begin
    PAD_READ = PAD_NORMAL;
    if (cfg_info_en) begin
      case (PAD_SEL)
        3'h0: PAD_READ = {REG_BASE[31:10], 10'h0};
        3'h1: PAD_READ = REG_BASE[63:32];
        3'h2: PAD_READ = RAM_BASE[31:0];
        3'h3: PAD_READ = RAM_BASE[63:32];
        3'h4: PAD_READ = {8'h0, REVISION_ID_VALUE, DEVICE_ID_VALUE};
        default: PAD_READ = PAD_NORMAL;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Registers and side effects
  // ---------------------------------------------------------------
  always @(posedge CORE_CLK) begin
    if (!RST_B) begin
      RDATA <= 32'h0;
      irq_mask <= 1'b0;
      irq_blocked <= 1'b0;
      IRQ_LINE_B <= 1'b1;
      MAILBOX_ZERO <= `DFS_ZERO_BYTE;
      MAILBOX_ONE <= `DFS_ZERO_BYTE;
      cfg_info_en <= 1'b0;
      flush_ctl <= 1'b0;
      FLUSHING <= 1'b0;
      winv_en <= 1'b0;
      steer_en <= 1'b0;
      shadow_mode <= 1'b0;
      MASTER_PARITY_ENABLE <= 1'b0;
      lane_sel <= 3'h0;
      burst_msb <= 1'b0;
      return_pointer <= 32'h0;
      shadow_return_pointer <= 32'h0;
      SHADOW_TABLE_BASE <= 32'h0;
      FETCH_LOAD <= 1'b0;
      FETCH_POINTER <= 32'h0;
      SIGNAL_PROCESS_CLR <= 1'b0;
      FLUSH_DIRECTION_SIGNAL <= 1'b0;
      WRITE_INVALIDATE_OK <= 1'b0;
      PARITY_IRQ <= 1'b0;
      BURST_LENGTH_MSB <= 3'h0;
      NEXT_TRANSFER_ADDRESS <= 32'h0;
      TRANSFER_BYTE_COUNTER <= 24'h0;
      for (j = 0; j < LANES; j = j + 1) begin
        top[j] <= {(PW+1){1'b0}};
        bot[j] <= {(PW+1){1'b0}};
      end
    end else begin
      RDATA <= RD ? next_rdata : 32'h0;
      // Read side effect: clears the original flag
      SIGNAL_PROCESS_CLR <= RD && ADDR == `DFS_CFG_SHADOW;
      // Interrupt line, active low; a pending line rides out the mask
      if (WR && ADDR == `DFS_AUX_STATUS)
        irq_mask <= WDATA[`DFS_MASK_BIT];
      if (!irq_mask)
        irq_blocked <= 1'b0;
      else if (IRQ_SERVICED)
        irq_blocked <= 1'b1;
      if (!irq_mask)
        IRQ_LINE_B <= !IRQ_REQUEST;
      else if (irq_blocked || IRQ_SERVICED)
        IRQ_LINE_B <= 1'b1;
      // Mailboxes: host write wins a same-cycle collision
      if (SEQ_MBOX_WR && !SEQ_MBOX_SEL)
        MAILBOX_ZERO <= SEQ_MBOX_DATA;
      if (SEQ_MBOX_WR && SEQ_MBOX_SEL)
        MAILBOX_ONE <= SEQ_MBOX_DATA;
      if (WR && ADDR == `DFS_MAILBOX0)
        MAILBOX_ZERO <= WDATA[7:0];
      if (WR && ADDR == `DFS_MAILBOX1)
        MAILBOX_ONE <= WDATA[7:0];
      // Only the enable bit of the shadow control takes a write
      if (WR && ADDR == `DFS_CFG_SHADOW)
        cfg_info_en <= WDATA[`DFS_CIE_BIT];
      if (WR && ADDR == `DFS_FLUSH_CLEAR) begin
        flush_ctl <= WDATA[`DFS_FLUSH_BIT];
        winv_en <= WDATA[`DFS_WINV_BIT];
      end
      // Flush runs while control set and data remain
      FLUSHING <= flush_ctl && !FLUSH_DONE && !(&empty_flags);
      FLUSH_DIRECTION_SIGNAL <= flush_ctl;
      WRITE_INVALIDATE_OK <= winv_en && CMD_WRITE_INVALIDATE;
      if (WR && ADDR == `DFS_LANE_TEST) begin
        steer_en <= WDATA[`DFS_STEER_BIT];
        shadow_mode <= WDATA[`DFS_SHADOW_BIT];
        MASTER_PARITY_ENABLE <= WDATA[`DFS_PARITY_EN_BIT];
        lane_sel <= WDATA[2:0];
      end
      PARITY_IRQ <= MASTER_PARITY_ENABLE && MASTER_PARITY_ERR;
      if (WR && ADDR == `DFS_CNT_STEP)
        burst_msb <= WDATA[`DFS_BURST_MSB_BIT];
      BURST_LENGTH_MSB <= {burst_msb, DMODE_BL};
      // Return pointer; host write redirected in shadow mode
      FETCH_LOAD <= SEQ_RETURN;
      if (SEQ_RETURN)
        FETCH_POINTER <= return_pointer;
      if (MEM_MOVE)
        shadow_return_pointer <= return_pointer;
      else if (SEQ_CALL)
        return_pointer <= CALL_RETURN_ADDR;
      if (wr_rp && shadow_mode)
        shadow_return_pointer <= WDATA;
      else if (wr_rp)
        return_pointer <= WDATA;
      if (wr_tb && shadow_mode)
        SHADOW_TABLE_BASE <= WDATA;
      else if (MEM_MOVE)
        SHADOW_TABLE_BASE <= TABLE_BASE_IN;
      // Address and counter stepping; pulses never store
      if (ADDR_LOAD_EN)
        NEXT_TRANSFER_ADDRESS <= ADDR_LOAD;
      else if (WR && ADDR == `DFS_CNT_STEP && WDATA[`DFS_ADDR_STEP_BIT])
        NEXT_TRANSFER_ADDRESS <= NEXT_TRANSFER_ADDRESS + {28'h0,
          step_size(NEXT_TRANSFER_ADDRESS, TRANSFER_BYTE_COUNTER)};
      if (COUNT_LOAD_EN)
        TRANSFER_BYTE_COUNTER <= COUNT_LOAD;
      else if (WR && ADDR == `DFS_CNT_STEP && WDATA[`DFS_CNT_STEP_BIT])
        TRANSFER_BYTE_COUNTER <= TRANSFER_BYTE_COUNTER - {20'h0,
          step_size(NEXT_TRANSFER_ADDRESS, TRANSFER_BYTE_COUNTER)};
      // FIFO test port and clear; clear leaves memory contents alone
      if (WR && ADDR == `DFS_FLUSH_CLEAR && WDATA[`DFS_CLEAR_BIT]) begin
        for (j = 0; j < LANES; j = j + 1) begin
          top[j] <= {(PW+1){1'b0}};
          bot[j] <= {(PW+1){1'b0}};
        end
      end else begin
        if (port_wr && !full_flags[cur_lane]) begin
          fifo_mem[{cur_lane, top[cur_lane][PW-1:0]}] <= WDATA[7:0];
          top[cur_lane] <= top[cur_lane] + 1'b1;
        end
        if (port_rd && !empty_flags[cur_lane])
          bot[cur_lane] <= bot[cur_lane] + 1'b1;
      end
    end
  end

endmodule // dfs_regs

// [tb/dfs_regs_asserts.sv]
// Port-level checks of the status, mailbox and FIFO test bank
`timescale 1ns/1ps
`include "dfs_defs.vh"
module dfs_regs_chk (
  input wire CORE_CLK,
  input wire RST_B,
  input wire [7:0] ADDR,
  input wire [31:0] WDATA,
  input wire WR,
  input wire RD,
  input wire [7:0] MAILBOX_ZERO,
  input wire [7:0] MAILBOX_ONE,
  input wire SEQ_MBOX_WR,
  input wire SEQ_MBOX_SEL,
  input wire [7:0] SEQ_MBOX_DATA,
  input wire SEQ_CALL,
  input wire SEQ_RETURN,
  input wire [31:0] CALL_RETURN_ADDR,
  input wire MEM_MOVE,
  input wire FETCH_LOAD,
  input wire [31:0] FETCH_POINTER,
  input wire SIGNAL_PROCESS_CLR,
  input wire CMD_WRITE_INVALIDATE,
  input wire WRITE_INVALIDATE_OK,
  input wire MASTER_PARITY_ERR,
  input wire MASTER_PARITY_ENABLE,
  input wire PARITY_IRQ,
  input wire IRQ_REQUEST,
  input wire IRQ_LINE_B,
  input wire [31:0] NEXT_TRANSFER_ADDRESS,
  input wire [23:0] TRANSFER_BYTE_COUNTER,
  input wire ADDR_LOAD_EN,
  input wire COUNT_LOAD_EN
);
  // ----------------------------------------------------------------
  // Clocking and step size
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  // Bytes left in the 8-byte line, capped by the count
  wire [23:0] room = 24'd8 - {21'h0, NEXT_TRANSFER_ADDRESS[2:0]};
  wire [23:0] step = (TRANSFER_BYTE_COUNTER < room) ?
    TRANSFER_BYTE_COUNTER : room;
  wire step_wr = WR && ADDR == `DFS_CNT_STEP;
  sequence s_call;
    SEQ_CALL && !MEM_MOVE && !WR;
  endsequence
  sequence s_ret;
    SEQ_RETURN && !SEQ_CALL && !WR;
  endsequence
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_MBOX_HOST: assert property (
    WR && ADDR == `DFS_MAILBOX0 |=> MAILBOX_ZERO == $past(WDATA[7:0]))
    else $error("host mailbox write lost");
  AST_MBOX_SEQ: assert property (
    SEQ_MBOX_WR && !WR |=> ($past(SEQ_MBOX_SEL) ? MAILBOX_ONE :
    MAILBOX_ZERO) == $past(SEQ_MBOX_DATA))
    else $error("sequencer mailbox write lost");
  AST_SIGNAL_PROCESS_FLAG_CLR: assert property (
    SIGNAL_PROCESS_CLR == $past(RD && ADDR == `DFS_CFG_SHADOW))
    else $error("signal flag clear not tied to read");
  AST_CALL_RET: assert property (
    s_call ##1 s_ret |=> FETCH_LOAD &&
    FETCH_POINTER == $past(CALL_RETURN_ADDR, 2))
    else $error("return did not load the call address");
  AST_WINV_GATE: assert property (
    !CMD_WRITE_INVALIDATE ##1 !CMD_WRITE_INVALIDATE |-> !WRITE_INVALIDATE_OK)
    else $error("invalidate allowed without command bit");
  AST_PARITY_GATE: assert property (
    $rose(PARITY_IRQ) |-> $past(MASTER_PARITY_ENABLE && MASTER_PARITY_ERR))
    else $error("parity interrupt while checking off");
  AST_IRQ_CAUSE: assert property (
    $fell(IRQ_LINE_B) |-> $past(IRQ_REQUEST))
    else $error("interrupt line asserted without request");
  AST_ADDR_STEP: assert property (
    step_wr && WDATA[7] && !WDATA[6] && !ADDR_LOAD_EN |=>
    NEXT_TRANSFER_ADDRESS == $past(NEXT_TRANSFER_ADDRESS) + {8'h0, $past(step)})
    else $error("address step amount wrong");
  AST_CNT_STEP: assert property (
    step_wr && WDATA[6] && !WDATA[7] && !COUNT_LOAD_EN |=>
    TRANSFER_BYTE_COUNTER == $past(TRANSFER_BYTE_COUNTER) - $past(step))
    else $error("counter step amount wrong");
endmodule // dfs_regs_chk

bind dfs_regs dfs_regs_chk chk (.*);

// [tb/dfs_seq_model.sv]
// Sequencer-side partner: mailbox writes, call and return, interrupts
`timescale 1ns/1ps
module dfs_seq_model (
  input wire clk,
  output logic running,
  output logic mbox_wr,
  output logic mbox_sel,
  output logic [7:0] mbox_data,
  output logic call,
  output logic ret,
  output logic [31:0] ret_addr,
  output logic move,
  output logic irq_req,
  output logic served
);
  // ----------------------------------------------------------------
  // Idle levels and strobes
  // ----------------------------------------------------------------
  initial begin
    {running, mbox_wr, mbox_sel, call, ret, move, irq_req, served} = 8'h0;
    mbox_data = 8'h0;
    ret_addr = 32'h0;
  end
  // One mailbox write; data turns stale afterwards
  task automatic mbox(input logic sel, input logic [7:0] d);
    mbox_sel <= sel;
    mbox_data <= d;
    mbox_wr <= 1'b1;
    @(posedge clk);
    mbox_wr <= 1'b0;
    mbox_data <= ~d;
  endtask
  // Call, optional memory move, then return
  task automatic call_ret(input logic [31:0] a, input logic mv);
    call <= 1'b1;
    ret_addr <= a;
    @(posedge clk);
    call <= 1'b0;
    ret_addr <= ~a;
    if (mv) begin
      move <= 1'b1;
      @(posedge clk);
      move <= 1'b0;
    end
    ret <= 1'b1;
    @(posedge clk);
    ret <= 1'b0;
  endtask
  task automatic service();
    served <= 1'b1;
    @(posedge clk);
    served <= 1'b0;
  endtask
endmodule // dfs_seq_model

// [tb/test_dfs_regs.sv]
// Self-checking bench of the status, mailbox and FIFO test bank
`timescale 1ns/1ps
`include "dfs_defs.vh"
module test_dfs_regs;
  // ----------------------------------------------------------------
  // Signals, named as the design ports
  // ----------------------------------------------------------------
  localparam logic [63:0] RBASE = 64'h0000_00a1_f000_0000;
  localparam logic [63:0] RAMB = 64'h0000_00b2_e000_2000;
  localparam logic [7:0] REVN = 8'h01; // arbitrary value
  localparam logic [15:0] DEVN = 16'h0abc; // arbitrary value
  logic CORE_CLK = 0, RST_B = 0, WR = 0, RD = 0;
  logic [7:0] ADDR = 0, SEQ_MBOX_DATA, MAILBOX_ZERO, MAILBOX_ONE;
  logic [31:0] WDATA = 0, RDATA, FETCH_POINTER, SHADOW_TABLE_BASE, PAD_READ;
  logic [31:0] TABLE_BASE_IN = 32'h4400, PAD_NORMAL = 0, ADDR_LOAD = 0;
  logic [31:0] CALL_RETURN_ADDR, NEXT_TRANSFER_ADDRESS;
  logic [23:0] COUNT_LOAD = 0, TRANSFER_BYTE_COUNTER;
  logic [63:0] REG_BASE = RBASE, RAM_BASE = RAMB;
  logic [7:0] REVISION_ID_VALUE = REVN;
  logic [15:0] DEVICE_ID_VALUE = DEVN;
  logic [2:0] PAD_SEL = 0, BURST_LENGTH_MSB;
  logic [1:0] DMODE_BL = 0;
  logic SEQ_RUNNING, SEQ_MBOX_WR, SEQ_MBOX_SEL, SEQ_CALL, SEQ_RETURN, MEM_MOVE;
  logic IRQ_REQUEST, IRQ_SERVICED, IRQ_LINE_B, FETCH_LOAD, SIGNAL_PROCESS_CLR;
  logic SIGNAL_PROCESS_FLAG = 0, IO_SPACE_ENABLED = 0, FLUSH_DONE = 0;
  logic MEMORY_SPACE_ENABLED = 0, CMD_WRITE_INVALIDATE = 0, PARITY_IRQ;
  logic FLUSHING, FLUSH_DIRECTION_SIGNAL, WRITE_INVALIDATE_OK;
  logic MASTER_PARITY_ENABLE, MASTER_PARITY_ERR = 0;
  logic ADDR_LOAD_EN = 0, COUNT_LOAD_EN = 0;
  int bad_count = 0, checks = 0;
  logic [31:0] pad_exp [5];
  `define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
  dfs_regs uut (.*);
  dfs_seq_model seq (.clk(CORE_CLK), .running(SEQ_RUNNING),
    .mbox_wr(SEQ_MBOX_WR), .mbox_sel(SEQ_MBOX_SEL), .mbox_data(SEQ_MBOX_DATA),
    .call(SEQ_CALL), .ret(SEQ_RETURN), .ret_addr(CALL_RETURN_ADDR),
    .move(MEM_MOVE), .irq_req(IRQ_REQUEST), .served(IRQ_SERVICED));
  always #5 CORE_CLK = ~CORE_CLK;
  // ----------------------------------------------------------------
  // Bus tasks; wr and rd stimulus moves 1 ns after an edge
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge CORE_CLK);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    tick(1);
    WR <= 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    ADDR <= a;
    RD <= 1'b1;
    tick(1);
    RD <= 1'b0;
    `CHK($sformatf("reg %h", a), e, RDATA)
    tick(1);
  endtask
  task automatic test_done();
    if (bad_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Hang guard
  initial begin
    #200000;
    bad_count++;
    test_done();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    tick(10);
    RST_B <= 1'b1;
    tick(1);
    rd(`DFS_EMPTY_LANES, 32'hff);
    rd(`DFS_LANE_TEST, 32'h0);
    rd(`DFS_RESERVED, 32'h0);
    rd(8'h40, 32'h0);
    wr(`DFS_MAILBOX0, 32'h5a);
    seq.mbox(1'b1, 8'hc3);
    tick(0);
    rd(`DFS_MAILBOX0, 32'h5a);
    rd(`DFS_MAILBOX1, 32'hc3);
    seq.running <= 1'b1;
    wr(`DFS_AUX_STATUS, 32'hff);
    rd(`DFS_AUX_STATUS, 32'h3);
    wr(`DFS_AUX_STATUS, 32'h0);
    rd(`DFS_AUX_STATUS, 32'h2);
    seq.running <= 1'b0;
    // Mask set over a pending request, then service and unmask
    seq.irq_req <= 1'b1;
    tick(2);
    `CHK("irq", 1'b0, IRQ_LINE_B)
    wr(`DFS_AUX_STATUS, 32'h1);
    `CHK("irq held", 1'b0, IRQ_LINE_B)
    seq.irq_req <= 1'b0;
    seq.service();
    seq.irq_req <= 1'b1;
    tick(2);
    `CHK("irq blocked", 1'b1, IRQ_LINE_B)
    wr(`DFS_AUX_STATUS, 32'h0);
    tick(1);
    `CHK("irq unmasked", 1'b0, IRQ_LINE_B)
    seq.irq_req <= 1'b0;
    // Call and return, plain and across a memory move
    seq.call_ret(32'h1230, 1'b0);
    tick(0);
    `CHK("fetch", 32'h1230, FETCH_POINTER)
    seq.call_ret(32'h2460, 1'b1);
    tick(0);
    `CHK("fetch move", 32'h2460, FETCH_POINTER)
    `CHK("shadow tbl", 32'h4400, SHADOW_TABLE_BASE)
    wr(`DFS_LANE_TEST, 32'h10);
    wr(`DFS_RET_PTR0, 32'hbeef);
    wr(`DFS_TBL_BASE0, 32'h77);
    `CHK("tbl", 32'h77, SHADOW_TABLE_BASE)
    rd(`DFS_RET_PTR0, 32'hbeef);
    wr(`DFS_LANE_TEST, 32'h0);
    rd(`DFS_RET_PTR0, 32'h2460);
    // Shadow control and configuration view
    SIGNAL_PROCESS_FLAG <= 1'b1;
    IO_SPACE_ENABLED <= 1'b1;
    MEMORY_SPACE_ENABLED <= 1'b1;
    wr(`DFS_CFG_SHADOW, 32'h08);
    rd(`DFS_CFG_SHADOW, 32'h78);
    SIGNAL_PROCESS_FLAG <= 1'b0;
    pad_exp = '{RBASE[31:0], RBASE[63:32], RAMB[31:0], RAMB[63:32],
      {8'h0, REVN, DEVN}};
    for (int s = 0; s < 5; s++) begin
      PAD_SEL <= 3'(s);
      tick(1);
      `CHK("pad", pad_exp[s], PAD_READ)
    end
    PAD_NORMAL <= 32'h600d;
    wr(`DFS_CFG_SHADOW, 32'h0);
    `CHK("pad normal", 32'h600d, PAD_READ)
    // Fill lane 3 through the test port, then flush and clear
    wr(`DFS_LANE_TEST, 32'h43);
    for (int i = 0; i < 4; i++) wr(`DFS_FIFO_PORT, 32'h10 + i);
    rd(`DFS_FULL_LANES, 32'h08);
    rd(`DFS_EMPTY_LANES, 32'hf7);
    rd(`DFS_FIFO_PORT, 32'h10);
    wr(`DFS_FLUSH_CLEAR, 32'h08);
    `CHK("dir", 1'b1, FLUSH_DIRECTION_SIGNAL)
    rd(`DFS_AUX_STATUS, 32'h4);
    rd(`DFS_FLUSH_CLEAR, 32'h08);
    FLUSH_DONE <= 1'b1;
    wr(`DFS_FLUSH_CLEAR, 32'h04);
    rd(`DFS_FLUSH_CLEAR, 32'h0);
    rd(`DFS_EMPTY_LANES, 32'hff);
    rd(`DFS_AUX_STATUS, 32'h0);
    wr(`DFS_LANE_TEST, 32'h0);
    CMD_WRITE_INVALIDATE <= 1'b1;
    wr(`DFS_FLUSH_CLEAR, 32'h01);
    `CHK("invalidate", 1'b1, WRITE_INVALIDATE_OK)
    CMD_WRITE_INVALIDATE <= 1'b0;
    tick(2);
    `CHK("invalidate off", 1'b0, WRITE_INVALIDATE_OK)
    MASTER_PARITY_ERR <= 1'b1;
    tick(2);
    `CHK("parity off", 1'b0, PARITY_IRQ)
    wr(`DFS_LANE_TEST, 32'h08);
    `CHK("parity on", 1'b1, PARITY_IRQ)
    MASTER_PARITY_ERR <= 1'b0;
    // Address and counter stepping, burst length bit
    ADDR_LOAD <= 32'h1005;
    COUNT_LOAD <= 24'h10;
    ADDR_LOAD_EN <= 1'b1;
    COUNT_LOAD_EN <= 1'b1;
    tick(1);
    ADDR_LOAD_EN <= 1'b0;
    COUNT_LOAD_EN <= 1'b0;
    wr(`DFS_CNT_STEP, 32'h80);
    `CHK("addr", 32'h1008, NEXT_TRANSFER_ADDRESS)
    wr(`DFS_CNT_STEP, 32'h40);
    `CHK("count", 24'h8, TRANSFER_BYTE_COUNTER)
    wr(`DFS_CNT_STEP, 32'h80);
    `CHK("addr", 32'h1010, NEXT_TRANSFER_ADDRESS)
    DMODE_BL <= 2'b01;
    wr(`DFS_CNT_STEP, 32'h04);
    `CHK("burst", 3'b101, BURST_LENGTH_MSB)
    rd(`DFS_CNT_STEP, 32'h04);
    test_done();
  end
endmodule // test_dfs_regs
